// ---- servo_status_pkg.sv ----
// Shared constants, register map and carrier types of the servo status outputs
`default_nettype none
package servo_status_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int WARN_LEAD_NS = 1000;
  localparam int WARN_LEAD_CYC = (WARN_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ZERO_SPEED = 8'h04;
  localparam logic [7:0] OFS_TARGET_SPEED = 8'h08;
  localparam logic [7:0] OFS_INPOS_BAND = 8'h0c;
  localparam logic [7:0] OFS_TORQUE_LIMIT = 8'h10;
  localparam logic [7:0] OFS_DO_MAP = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h1c;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h20;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h24;

  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] ZERO_SPEED_RST = 32'h0000_000a;
  localparam logic [31:0] TARGET_SPEED_RST = 32'h0000_0bb8;
  localparam logic [31:0] INPOS_BAND_RST = 32'h0000_0063;
  localparam logic [31:0] TORQUE_LIMIT_RST = 32'h0000_0064;
  localparam logic [31:0] DO_MAP_RST = 32'h0000_0000;
  localparam logic [31:0] IRQ_ENABLE_RST = 32'h0000_0000;

  // Control, map and status register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_MODE_W = 4;
  localparam int CTRL_CUSTOM_MAP_BIT = 4;
  localparam int CTRL_TQ_EXT_BIT = 5;
  localparam int MAP_FIELD_W = 4;
  localparam int STATUS_TERM_LSB = 16;

  // Interrupt status bits
  localparam int IRQ_ALARM = 0;
  localparam int IRQ_WARN = 1;
  localparam int IRQ_INPOS = 2;
  localparam int IRQ_TORQUE = 3;
  localparam int IRQ_READY_LOST = 4;
  localparam int IRQ_W = 5;

  // Functions that a terminal can carry
  typedef enum logic [3:0] {
    FN_OFF = 4'h0, FN_READY = 4'h1, FN_POWER = 4'h2, FN_ZERO = 4'h3,
    FN_SPEED = 4'h4, FN_INPOS = 4'h5, FN_TORQUE = 4'h6, FN_ALARM = 4'h7,
    FN_WARN = 4'h8
  } do_func_t;
  localparam int FN_COUNT = 9;

  // Control modes
  typedef enum logic [3:0] {
    M_PULSE = 4'h0, M_REG = 4'h1, M_S = 4'h2, M_T = 4'h3, M_SZ = 4'h4,
    M_TZ = 4'h5, M_PULSE_S = 4'h6, M_PULSE_T = 4'h7, M_REG_S = 4'h8,
    M_REG_T = 4'h9, M_S_T = 4'ha
  } ctrl_mode_t;

  // Fault sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00, SEQ_WARN = 2'b01, SEQ_ALARM = 2'b11
  } seq_state_t;

  // Drive state sampled each control cycle
  typedef struct packed {
    logic can_run;
    logic [15:0] speed_mag;
    logic [31:0] pos_err_mag;
    logic signed [31:0] pos_act;
    logic signed [31:0] pos_tgt;
    logic [15:0] torque_mag;
    logic [15:0] torque_ext_lim;
  } drive_state_t;

  // Fault sources
  typedef struct packed {
    logic rev_limit;
    logic fwd_limit;
    logic estop;
    logic comm_err;
    logic undervolt;
    logic other_fault;
  } fault_set_t;

endpackage
`default_nettype wire

// ---- servo_status_out.sv ----
// Programmable digital status outputs of the servo drive
//
// Overview of operation
// - Each terminal's function configurable, mode-based defaults
// - Terminals fixed, functions swappable between them
// - Ready only when runnable and fault-free
// - Power-on follows control power; default unrouted
// - Zero speed while speed at/below threshold
// - Speed reached at target; off in pure position
// - Pulse mode: in-position when error within threshold
// - Register mode: in-position within target band
// - Torque limit from internal or external limit
// - Alarm output at once on other faults, on listed faults only once held through the lead time
// - Listed faults raise warning before alarm
`timescale 1ns/1ns
`default_nettype none
module servo_status_out
  import servo_status_pkg::*;
#(
  parameter int NUM_DO = 5,
  parameter int WARN_CYC = WARN_LEAD_CYC
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ce,
  input wire drive_state_t drive_in,
  input wire fault_set_t faults_in,
  input wire logic ctrl_power_pin,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  output logic [NUM_DO-1:0] do_terminal
);

  localparam int CNT_W = $clog2(WARN_CYC + 1);
  localparam logic [CNT_W-1:0] WARN_LAST = CNT_W'(WARN_CYC - 1);

  // ==========================================================================
  // Registers and state
  logic [31:0] ctrl_ff, zero_speed_ff, target_speed_ff;
  logic [31:0] band_ff, tq_limit_ff, map_ff;
  logic [IRQ_W-1:0] irq_stat_ff, irq_en_ff, nxt_irq_stat;
  logic wait_ff, irq_ff;
  logic [31:0] rdata_ff;
  logic pwr_s1_ff, pwr_s2_ff;
  seq_state_t seq_ff;
  logic [CNT_W-1:0] lead_cnt_ff;
  logic ready_to_run_out_ff, control_power_on_out_ff, zero_speed_out_ff;
  logic speed_reached_out_ff, in_position_out_ff, torque_limit_out_ff;
  logic alarm_out_ff, warn_ff;
  logic [NUM_DO-1:0] term_ff;
  logic [FN_COUNT-1:0] func_vec;
  logic [NUM_DO*MAP_FIELD_W-1:0] eff_map;
  ctrl_mode_t mode;
  logic pulse_mode, pulse_position_mode, register_position_mode;
  logic warn_class, any_fault;
  logic signed [32:0] pos_diff;
  logic [32:0] pos_dist;
  logic [15:0] tq_lim;
  logic bus_req, bus_take;
  logic [31:0] rd_mux;

  assign mode = ctrl_mode_t'(ctrl_ff[CTRL_MODE_LSB +: CTRL_MODE_W]);
  assign pulse_mode = (mode == M_PULSE) || (mode == M_REG);
  assign pulse_position_mode = (mode == M_PULSE) || (mode == M_PULSE_S) ||
                               (mode == M_PULSE_T);
  assign register_position_mode = (mode == M_REG) || (mode == M_REG_S) ||
                                  (mode == M_REG_T);
  assign warn_class = faults_in.rev_limit | faults_in.fwd_limit |
                      faults_in.estop | faults_in.comm_err |
                      faults_in.undervolt;
  assign any_fault = warn_class | faults_in.other_fault;

  // ==========================================================================
  // Avalon-MM slave: one wait state, answer on the following edge
  assign bus_req = avs_read | avs_write;
  assign bus_take = bus_req & ~wait_ff;

  // Byte-lane merge for partial writes
  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Read multiplexer; unmapped and write-only offsets read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (avs_address)
      OFS_CTRL: rd_mux = ctrl_ff;
      OFS_ZERO_SPEED: rd_mux = zero_speed_ff;
      OFS_TARGET_SPEED: rd_mux = target_speed_ff;
      OFS_INPOS_BAND: rd_mux = band_ff;
      OFS_TORQUE_LIMIT: rd_mux = tq_limit_ff;
      OFS_DO_MAP: rd_mux = map_ff;
      OFS_STATUS: begin
        rd_mux[FN_COUNT-1:0] = func_vec;
        rd_mux[STATUS_TERM_LSB +: NUM_DO] = term_ff;
      end
      OFS_IRQ_STATUS: rd_mux[IRQ_W-1:0] = irq_stat_ff;
      OFS_IRQ_ENABLE: rd_mux[IRQ_W-1:0] = irq_en_ff;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Handshake and read data
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wait_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end else if (ce) begin
      wait_ff <= ~(bus_req & wait_ff);
      if (bus_req & wait_ff) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_ff <= CTRL_RST;
      zero_speed_ff <= ZERO_SPEED_RST;
      target_speed_ff <= TARGET_SPEED_RST;
      band_ff <= INPOS_BAND_RST;
      tq_limit_ff <= TORQUE_LIMIT_RST;
      map_ff <= DO_MAP_RST;
      irq_en_ff <= IRQ_ENABLE_RST[IRQ_W-1:0];
    end else if (ce && bus_take && avs_write) begin
      unique case (avs_address)
        OFS_CTRL: ctrl_ff <= be_merge(ctrl_ff, avs_writedata, avs_byteenable);
        OFS_ZERO_SPEED:
          zero_speed_ff <= be_merge(zero_speed_ff, avs_writedata,
                                    avs_byteenable);
        OFS_TARGET_SPEED:
          target_speed_ff <= be_merge(target_speed_ff, avs_writedata,
                                      avs_byteenable);
        OFS_INPOS_BAND:
          band_ff <= be_merge(band_ff, avs_writedata, avs_byteenable);
        OFS_TORQUE_LIMIT:
          tq_limit_ff <= be_merge(tq_limit_ff, avs_writedata, avs_byteenable);
        OFS_DO_MAP: map_ff <= be_merge(map_ff, avs_writedata, avs_byteenable);
        OFS_IRQ_ENABLE:
          irq_en_ff <= IRQ_W'(be_merge(32'(irq_en_ff), avs_writedata,
                                       avs_byteenable));
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Control power pin synchroniser
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pwr_s1_ff <= 1'b0;
      pwr_s2_ff <= 1'b0;
    end else if (ce) begin
      pwr_s1_ff <= ctrl_power_pin;
      pwr_s2_ff <= pwr_s1_ff;
    end
  end

  // ==========================================================================
  // Fault sequencer: listed faults warn first, then alarm after a lead time
  always_ff @(posedge core_clk) begin
    if (srst) begin
      seq_ff <= SEQ_IDLE;
      lead_cnt_ff <= '0;
    end else if (ce) begin
      unique case (seq_ff)
        SEQ_IDLE: begin
          lead_cnt_ff <= '0;
          if (warn_class) begin
            seq_ff <= SEQ_WARN;
          end
        end
        SEQ_WARN: begin
          if (!warn_class) begin
            seq_ff <= SEQ_IDLE;
          end else if (lead_cnt_ff == WARN_LAST) begin
            seq_ff <= SEQ_ALARM;
          end else begin
            lead_cnt_ff <= lead_cnt_ff + 1'b1;
          end
        end
        SEQ_ALARM: begin
          if (!warn_class) begin
            seq_ff <= SEQ_IDLE;
          end
        end
        default: seq_ff <= SEQ_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Condition evaluation, one registered level per function
  assign pos_diff = {drive_in.pos_act[31], drive_in.pos_act} -
                    {drive_in.pos_tgt[31], drive_in.pos_tgt};
  assign pos_dist = pos_diff[32] ? 33'(-pos_diff) : 33'(pos_diff);
  assign tq_lim = ctrl_ff[CTRL_TQ_EXT_BIT] ? drive_in.torque_ext_lim :
                  tq_limit_ff[15:0];

  // Status levels follow their conditions every enabled cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ready_to_run_out_ff <= 1'b0;
      control_power_on_out_ff <= 1'b0;
      zero_speed_out_ff <= 1'b0;
      speed_reached_out_ff <= 1'b0;
      in_position_out_ff <= 1'b0;
      torque_limit_out_ff <= 1'b0;
      alarm_out_ff <= 1'b0;
      warn_ff <= 1'b0;
    end else if (ce) begin
      ready_to_run_out_ff <= drive_in.can_run & ~any_fault &
                             (seq_ff == SEQ_IDLE);
      control_power_on_out_ff <= pwr_s2_ff;
      zero_speed_out_ff <= drive_in.speed_mag <= zero_speed_ff[15:0];
      speed_reached_out_ff <= ~pulse_mode &
        (drive_in.speed_mag >= target_speed_ff[15:0]);
      in_position_out_ff <=
        (pulse_position_mode & (drive_in.pos_err_mag <= band_ff)) |
        (register_position_mode & (pos_dist <= {1'b0, band_ff}));
      torque_limit_out_ff <= drive_in.torque_mag >= tq_lim;
      alarm_out_ff <= faults_in.other_fault | (seq_ff == SEQ_ALARM);
      warn_ff <= warn_class;
    end
  end

  // Function vector indexed by function code
  always_comb begin
    func_vec = '0;
    func_vec[FN_READY] = ready_to_run_out_ff;
    func_vec[FN_POWER] = control_power_on_out_ff;
    func_vec[FN_ZERO] = zero_speed_out_ff;
    func_vec[FN_SPEED] = speed_reached_out_ff;
    func_vec[FN_INPOS] = in_position_out_ff;
    func_vec[FN_TORQUE] = torque_limit_out_ff;
    func_vec[FN_ALARM] = alarm_out_ff;
    func_vec[FN_WARN] = warn_ff;
  end

  // ==========================================================================
  // Terminal routing: factory map per mode, or the user map
  function automatic logic [NUM_DO*MAP_FIELD_W-1:0] default_map(
      input ctrl_mode_t m);
    logic [NUM_DO*MAP_FIELD_W-1:0] res;
    logic pos;
    res = '0;
    pos = (m == M_PULSE) || (m == M_REG) || (m == M_PULSE_S) ||
          (m == M_PULSE_T) || (m == M_REG_S) || (m == M_REG_T);
    for (int t = 0; t < NUM_DO; t++) begin
      unique case (t)
        0: res[t*MAP_FIELD_W +: MAP_FIELD_W] = FN_READY;
        1: res[t*MAP_FIELD_W +: MAP_FIELD_W] = FN_ZERO;
        3: res[t*MAP_FIELD_W +: MAP_FIELD_W] = pos ? FN_INPOS : FN_SPEED;
        4: res[t*MAP_FIELD_W +: MAP_FIELD_W] = FN_ALARM;
        default: res[t*MAP_FIELD_W +: MAP_FIELD_W] = FN_OFF;
      endcase
    end
    return res;
  endfunction

  assign eff_map = ctrl_ff[CTRL_CUSTOM_MAP_BIT] ?
                   map_ff[NUM_DO*MAP_FIELD_W-1:0] : default_map(mode);

  // Each fixed terminal carries whichever function its field selects
  for (genvar t = 0; t < NUM_DO; t++) begin : g_term
    logic [MAP_FIELD_W-1:0] sel;
    assign sel = eff_map[t*MAP_FIELD_W +: MAP_FIELD_W];
    always_ff @(posedge core_clk) begin
      if (srst) begin
        term_ff[t] <= 1'b0;
      end else if (ce) begin
        term_ff[t] <= (sel < FN_COUNT) ? func_vec[sel] : 1'b0;
      end
    end
  end

  // ==========================================================================
  // Interrupts: sticky status, set wins over a same-cycle clear
  always_comb begin
    nxt_irq_stat = irq_stat_ff;
    if (bus_take && avs_write && avs_address == OFS_IRQ_CLEAR) begin
      nxt_irq_stat = irq_stat_ff & ~avs_writedata[IRQ_W-1:0];
    end
    nxt_irq_stat[IRQ_ALARM] |= faults_in.other_fault & ~alarm_out_ff;
    nxt_irq_stat[IRQ_WARN] |= warn_class & ~warn_ff;
    nxt_irq_stat[IRQ_INPOS] |= ~in_position_out_ff &
      ((pulse_position_mode & (drive_in.pos_err_mag <= band_ff)) |
       (register_position_mode & (pos_dist <= {1'b0, band_ff})));
    nxt_irq_stat[IRQ_TORQUE] |= ~torque_limit_out_ff &
                                (drive_in.torque_mag >= tq_lim);
    nxt_irq_stat[IRQ_READY_LOST] |= ready_to_run_out_ff & any_fault;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_stat_ff <= '0;
      irq_ff <= 1'b0;
    end else if (ce) begin
      irq_stat_ff <= nxt_irq_stat;
      irq_ff <= |(nxt_irq_stat & irq_en_ff);
    end
  end

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign irq = irq_ff;
  assign do_terminal = term_ff;

  // ==========================================================================
  // Assertions
  property p_zero_speed;
    @(posedge core_clk) disable iff (srst)
    (ce && drive_in.speed_mag <= zero_speed_ff[15:0]) |=> zero_speed_out_ff;
  endproperty
  a_zero_speed: assert property (p_zero_speed)
    else $error("zero speed not asserted at or below threshold");

  property p_speed_pure_pos;
    @(posedge core_clk) disable iff (srst)
    (ce && (mode == M_PULSE || mode == M_REG)) |=> !speed_reached_out_ff;
  endproperty
  a_speed_pure_pos: assert property (p_speed_pure_pos)
    else $error("speed reached shown in pure position mode");

  property p_ready_fault;
    @(posedge core_clk) disable iff (srst)
    (ce && any_fault) |=> !ready_to_run_out_ff;
  endproperty
  a_ready_fault: assert property (p_ready_fault)
    else $error("ready shown while a fault is present");

  property p_power;
    @(posedge core_clk) disable iff (srst)
    (ce && pwr_s2_ff && any_fault) |=> control_power_on_out_ff;
  endproperty
  a_power: assert property (p_power)
    else $error("power-on lost while control power present");

  property p_alarm;
    @(posedge core_clk) disable iff (srst)
    (ce && faults_in.other_fault) |=> alarm_out_ff;
  endproperty
  a_alarm: assert property (p_alarm)
    else $error("alarm missing on detected fault");

  property p_warn_first;
    @(posedge core_clk) disable iff (srst)
    (ce && seq_ff == SEQ_IDLE && warn_class && !faults_in.other_fault)
      |=> (warn_ff && !alarm_out_ff);
  endproperty
  a_warn_first: assert property (p_warn_first)
    else $error("alarm came before warning");

  property p_inpos_band;
    @(posedge core_clk) disable iff (srst)
    (ce && register_position_mode && pos_dist <= {1'b0, band_ff})
      |=> in_position_out_ff;
  endproperty
  a_inpos_band: assert property (p_inpos_band)
    else $error("in-position missing inside band");

  property p_inpos_pulse;
    @(posedge core_clk) disable iff (srst)
    (ce && pulse_position_mode && drive_in.pos_err_mag > band_ff)
      |=> !in_position_out_ff;
  endproperty
  a_inpos_pulse: assert property (p_inpos_pulse)
    else $error("in-position shown with error above threshold");

  property p_torque;
    @(posedge core_clk) disable iff (srst)
    (ce && drive_in.torque_mag >= tq_lim) |=> torque_limit_out_ff;
  endproperty
  a_torque: assert property (p_torque)
    else $error("torque limit output missing");

  property p_route;
    @(posedge core_clk) disable iff (srst)
    (ce && eff_map[MAP_FIELD_W-1:0] == FN_ALARM)
      |=> (do_terminal[0] == $past(alarm_out_ff));
  endproperty
  a_route: assert property (p_route)
    else $error("terminal 0 does not follow its selected function");

endmodule // servo_status_out
`default_nettype wire

// ---- servo_ctrl_reader.sv ----
// Model of the external controller that samples the status terminals
`timescale 1ns/1ns
`default_nettype none
module servo_ctrl_reader #(
  parameter int NUM_DO = 5
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [NUM_DO-1:0] do_terminal,
  output logic [NUM_DO-1:0] seen_ff
);
  // ==========================================================================
  // Scan
  // Capture the terminal levels once per control cycle, as a controller scan
  // would; the bench judges what the controller saw, not the raw pins
  always_ff @(posedge core_clk) begin
    if (srst) begin
      seen_ff <= '0;
    end else begin
      seen_ff <= do_terminal;
    end
  end
endmodule // servo_ctrl_reader
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking testbench of the servo status outputs
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import servo_status_pkg::*;
;
  localparam int WCYC = 8;
  logic core_clk, srst, ce, ctrl_power_pin, irq;
  drive_state_t drv;
  fault_set_t flt;
  logic [7:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable;
  logic [4:0] do_terminal, seen;
  int n_errors, samples_checked;

  servo_status_out #(.NUM_DO(5), .WARN_CYC(WCYC)) uut (
    .core_clk(core_clk), .srst(srst), .ce(ce), .drive_in(drv),
    .faults_in(flt), .ctrl_power_pin(ctrl_power_pin),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq(irq), .do_terminal(do_terminal));
  servo_ctrl_reader #(.NUM_DO(5)) reader (
    .core_clk(core_clk), .srst(srst), .do_terminal(do_terminal),
    .seen_ff(seen));

  // ==========================================================================
  // Helpers
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // One bus access; holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    if (n >= 100) chk(32'h0000_0000, 32'h0000_0001, "bus hang");
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Read one function level from the status register
  task automatic stat(input int code, input logic e, input string m);
    settle(4);
    bus(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(q[code], e, m);
  endtask

  // ==========================================================================
  // Scenarios
  // Reset values, readback, unmapped and write-only places
  task automatic t_regs;
    logic [7:0] ofs [9];
    logic [31:0] rv [9];
    ofs = '{OFS_CTRL, OFS_ZERO_SPEED, OFS_TARGET_SPEED, OFS_INPOS_BAND,
            OFS_TORQUE_LIMIT, OFS_DO_MAP, OFS_IRQ_ENABLE, OFS_IRQ_CLEAR, 8'h3c};
    rv = '{CTRL_RST, ZERO_SPEED_RST, TARGET_SPEED_RST, INPOS_BAND_RST,
           TORQUE_LIMIT_RST, DO_MAP_RST, IRQ_ENABLE_RST, 32'h0, 32'h0};
    bus(1'b1, 8'h3c, 32'hffff_ffff);
    for (int i = 0; i < 9; i++) begin
      bus(1'b0, ofs[i], 32'h0000_0000);
      chk(q, rv[i], "reset value");
    end
    bus(1'b1, OFS_ZERO_SPEED, 32'h0000_0014);
    bus(1'b0, OFS_ZERO_SPEED, 32'h0000_0000);
    chk(q, 32'h0000_0014, "threshold readback");
    bus(1'b1, OFS_ZERO_SPEED, ZERO_SPEED_RST);
    $display("test regs done");
  endtask
  // Zero speed at and above the threshold, default terminal map
  task automatic t_zero;
    drv.speed_mag <= 16'h000a;
    stat(FN_ZERO, 1'b1, "zero at threshold");
    chk(seen, 5'b01011, "default terminals");
    drv.speed_mag <= 16'h000b;
    stat(FN_ZERO, 1'b0, "zero above threshold");
    chk(seen[1], 1'b0, "zero terminal");
    // Clock enable low must freeze the levels
    ce <= 1'b0;
    drv.speed_mag <= 16'h0005;
    settle(5);
    chk(seen[1], 1'b0, "frozen while disabled");
    ce <= 1'b1;
    settle(5);
    chk(seen[1], 1'b1, "zero after enable");
    $display("test zero speed done");
  endtask
  // Speed reached in speed mode, forced off in pulse position mode
  task automatic t_speed;
    bus(1'b1, OFS_CTRL, {28'h000_0000, M_S});
    drv.speed_mag <= 16'h0bb8;
    stat(FN_SPEED, 1'b1, "speed at target");
    chk(seen[3], 1'b1, "speed terminal");
    stat(FN_INPOS, 1'b0, "no in-position in speed mode");
    drv.speed_mag <= 16'h0bb7;
    stat(FN_SPEED, 1'b0, "speed below target");
    bus(1'b1, OFS_CTRL, {28'h000_0000, M_PULSE});
    drv.speed_mag <= 16'h0bb8;
    stat(FN_SPEED, 1'b0, "speed in pulse mode");
    drv.speed_mag <= 16'h0000;
    $display("test speed reached done");
  endtask
  // In-position by error in pulse mode, by band in register mode
  task automatic t_inpos;
    drv.pos_err_mag <= 32'h0000_0063;
    stat(FN_INPOS, 1'b1, "error at band");
    drv.pos_err_mag <= 32'h0000_0064;
    stat(FN_INPOS, 1'b0, "error past band");
    bus(1'b1, OFS_CTRL, {28'h000_0000, M_REG});
    drv.pos_err_mag <= 32'h0000_1000;
    drv.pos_act <= 32'hffff_ff9d;
    stat(FN_INPOS, 1'b1, "lower band edge");
    drv.pos_act <= 32'h0000_0064;
    stat(FN_INPOS, 1'b0, "past upper edge");
    drv.pos_act <= 32'h0000_0063;
    stat(FN_INPOS, 1'b1, "upper band edge");
    drv.pos_act <= 32'h0000_0000;
    drv.pos_err_mag <= 32'h0000_0000;
    $display("test in-position done");
  endtask
  // Torque limit, internal and external, with its interrupt
  task automatic t_torque;
    bus(1'b1, OFS_CTRL, {28'h000_0000, M_S});
    bus(1'b1, OFS_IRQ_CLEAR, 32'h0000_001f);
    bus(1'b1, OFS_IRQ_ENABLE, 32'h0000_0008);
    drv.torque_mag <= 16'h0063;
    stat(FN_TORQUE, 1'b0, "torque below limit");
    chk(irq, 1'b0, "irq idle");
    drv.torque_mag <= 16'h0064;
    stat(FN_TORQUE, 1'b1, "torque at limit");
    drv.torque_mag <= 16'h0000;
    stat(FN_TORQUE, 1'b0, "torque released");
    chk(irq, 1'b1, "irq sticky");
    bus(1'b1, OFS_IRQ_CLEAR, 32'h0000_0008);
    settle(3);
    chk(irq, 1'b0, "irq cleared");
    bus(1'b1, OFS_IRQ_ENABLE, 32'h0000_0000);
    bus(1'b1, OFS_CTRL, 32'h0000_0022);
    drv.torque_ext_lim <= 16'h0032;
    drv.torque_mag <= 16'h003c;
    stat(FN_TORQUE, 1'b1, "external limit");
    chk(irq, 1'b0, "irq masked");
    bus(1'b0, OFS_IRQ_STATUS, 32'h0000_0000);
    chk(q[IRQ_TORQUE], 1'b1, "torque event seen");
    drv.torque_mag <= 16'h0028;
    stat(FN_TORQUE, 1'b0, "below external limit");
    drv.torque_mag <= 16'h0000;
    $display("test torque done");
  endtask
  // Warning before alarm, ready loss, power indication, remapping
  task automatic t_fault;
    int wf, af;
    wf = -1;
    af = -1;
    bus(1'b1, OFS_DO_MAP, 32'h0007_0821);
    bus(1'b1, OFS_CTRL, 32'h0000_0010);
    bus(1'b1, OFS_IRQ_CLEAR, 32'h0000_001f);
    bus(1'b1, OFS_IRQ_ENABLE, 32'h0000_0012);
    settle(4);
    chk(seen, 5'b00011, "user map");
    flt.estop <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(posedge core_clk);
      if (seen[2] === 1'b1 && wf < 0) wf = i;
      if (seen[4] === 1'b1 && af < 0) af = i;
    end
    chk(wf >= 0 && af > wf, 1'b1, "warning leads alarm");
    chk(seen[1:0], 2'b10, "ready off, power on");
    chk(irq, 1'b1, "fault irq");
    bus(1'b0, OFS_IRQ_STATUS, 32'h0000_0000);
    chk(q & 32'h0000_0012, 32'h0000_0012, "warn and ready lost");
    flt.estop <= 1'b0;
    settle(WCYC + 6);
    chk(seen, 5'b00011, "fault gone");
    flt.other_fault <= 1'b1;
    settle(6);
    chk(seen, 5'b10010, "other fault alarms");
    ctrl_power_pin <= 1'b0;
    settle(8);
    chk(seen[1], 1'b0, "power removed");
    ctrl_power_pin <= 1'b1;
    bus(1'b1, OFS_DO_MAP, 32'h0001_0827);
    settle(4);
    chk(seen, 5'b00011, "swapped map, fault");
    flt.other_fault <= 1'b0;
    settle(6);
    chk(seen, 5'b10010, "swapped map, clear");
    $display("test faults done");
  endtask

  // ==========================================================================
  // Verdict
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Watchdog, well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    $display("BAD at %0t: watchdog expired", $time);
    end_sim();
  end
  // Main sequence
  initial begin
    n_errors = 0;
    samples_checked = 0;
    srst = 1'b1;
    ce = 1'b1;
    ctrl_power_pin = 1'b1;
    drv = '0;
    drv.can_run = 1'b1;
    drv.torque_ext_lim = 16'hffff;
    flt = '0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hf;
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    t_regs();
    t_zero();
    t_speed();
    t_inpos();
    t_torque();
    t_fault();
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
